// ---- logic/conv_port_pkg.sv ----
// constants, state type and register lengths of the converter serial port
// assumes a single system clock; all serial pins are sampled by that clock
`default_nettype none
package conv_port_pkg;

    // ==========================================================
    // register map
    localparam int NUM_REGS = 12;
    localparam int REG_W = 24;
    localparam int ADDR_W = 4;
    localparam int LEN_W = 5;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_DATA = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_MODE = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_FILTER = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_DAC = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_LAST = 4'hB;
    localparam logic [REG_W-1:0] REG_RST = 24'h000000;
    localparam int STATUS_RDY_BIT = 7;

    // ==========================================================
    // command byte layout
    localparam logic [LEN_W-1:0] LEN_8 = 5'h08;
    localparam logic [LEN_W-1:0] LEN_16 = 5'h10;
    localparam logic [LEN_W-1:0] LEN_24 = 5'h18;
    localparam int DIR_HI_BIT = 5;
    localparam int DIR_LO_BIT = 4;
    localparam logic [1:0] DIR_WRITE = 2'h0;
    localparam logic [1:0] DIR_READ = 2'h1;
    localparam logic [1:0] DIR_CONT = 2'h2;
    localparam logic [1:0] DIR_STOP = 2'h3;

    // ==========================================================
    // mode word: top field selects calibration
    localparam int MODE_SEL_HI = 15;
    localparam int MODE_SEL_LO = 13;
    localparam logic [2:0] MODE_CAL_ZERO = 3'h4;
    localparam logic [2:0] MODE_CAL_FULL = 3'h5;

    // ==========================================================
    // port state, gray along cmd -> write / cmd -> read
    typedef enum logic [1:0] {
        ST_CMD = 2'h0,
        ST_WRITE = 2'h1,
        ST_READ = 2'h2
    } port_state_t;

    function automatic logic [LEN_W-1:0] reg_len(input logic [ADDR_W-1:0] a);
        logic [LEN_W-1:0] len;
        len = LEN_24;
        if (a == ADDR_STATUS || a == ADDR_DAC || a > ADDR_LAST) begin
            len = LEN_8;
        end else if (a == ADDR_MODE) begin
            len = LEN_16;
        end
        return len;
    endfunction

endpackage
`default_nettype wire

// ---- logic/pin_sync_if.sv ----
// synchronised serial pin levels passed from the sampler to the port core
// assumes both ends run on the same system clock
`timescale 1ns/100ps
`default_nettype none
interface pin_sync_if;
    logic sclk;
    logic cs_n;
    logic din;
    logic edge_polarity_select;
    modport src (output sclk, output cs_n, output din, output edge_polarity_select);
    modport dst (input sclk, input cs_n, input din, input edge_polarity_select);
endinterface
`default_nettype wire

// ---- logic/pin_sync.sv ----
// three-stage samplers for the serial pins and the polarity strap
// assumes pins are asynchronous to i_clk; a level is taken when stages agree
`timescale 1ns/100ps
`default_nettype none
module pin_sync (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_din,
    input wire logic i_pol,
    pin_sync_if.src sync
);
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;

    // ==========================================================
    // sampler chain
    always_ff @(posedge i_clk) begin
        s1 <= {i_pol, i_din, i_cs_n, i_sclk};
        s2 <= s1;
        s3 <= s2;
    end

    // ==========================================================
    // accept a change only when stages two and three agree
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            // follow the pins in reset, select held high, so no false edge shows at release
            sync.sclk <= s3[0];
            sync.cs_n <= 1'b1;
            sync.din <= s3[2];
            sync.edge_polarity_select <= s3[3];
        end else begin
            if (s2[0] == s3[0]) begin
                sync.sclk <= s3[0];
            end
            if (s2[1] == s3[1]) begin
                sync.cs_n <= s3[1];
            end
            if (s2[2] == s3[2]) begin
                sync.din <= s3[2];
            end
            if (s2[3] == s3[3]) begin
                sync.edge_polarity_select <= s3[3];
            end
        end
    end
endmodule
`default_nettype wire

// ---- logic/converter_serial_port.sv ----
// serial register port of a converter: command, write, read and ready logic
// assumes i_clk well above the serial clock; converter core drives results
//
// Function
// RULE1 - bits gather in input shifter, copied only after the full length
// RULE2 - dac write ends after 8 clocks, filter write after 24
// RULE3 - polarity high samples on rising edge, low on falling edge
// RULE4 - host parks serial clock at polarity level in three-wire use
// RULE5 - host launches on one edge, device captures on the opposite edge
// RULE6 - port-line select goes low well before the first clock edge
// RULE7 - frame-sync host settles msb before first active edge
// RULE8 - read start copies the register into the output shifter in parallel
// RULE9 - polarity high shifts out on falling edge, low on rising edge
// RULE10 - read bit driven after launch edge, host samples next edge
// RULE11 - select falling puts the output msb on data-out without clock
// RULE12 - after the msb, later bits change on the shifting edge
// RULE13 - ready goes low when a fresh result lands in data register
// RULE14 - ready returns high once a data register read completes
// RULE15 - ready goes high before an update; host avoids reading then
// RULE16 - same result may be read again after ready returned high
// RULE17 - host never uses continuous read on a shared data wire
// RULE18 - twelve registers reachable only through the serial port
// RULE19 - command 03 selects filter write, command 02 mode write
// RULE20 - mode words start full-scale or zero-scale calibration
// RULE21 - ready goes low when each calibration cycle completes
// RULE22 - host may skip the filter write when defaults suit
// RULE23 - after reset the first transfer is a command byte
// RULE24 - direction 01 single read, 10 continuous, 11 leaves continuous
// RULE25 - after any write the port expects a command byte again
// RULE26 - data-out released and bit counter restarted while select high
// RULE27 - no data driven onto data-out during writes
`timescale 1ns/100ps
`default_nettype none
module converter_serial_port (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_din,
    input wire logic i_edge_polarity_select,
    input wire logic i_result_valid,
    input wire logic [conv_port_pkg::REG_W-1:0] i_result,
    input wire logic i_update_soon,
    input wire logic i_cal_done,
    output logic o_dout,
    output logic o_dout_oe_n,
    output logic o_rdy_n,
    output logic [conv_port_pkg::REG_W-1:0] o_mode,
    output logic [conv_port_pkg::REG_W-1:0] o_filter,
    output logic [conv_port_pkg::REG_W-1:0] o_dac,
    output logic o_mode_load,
    output logic o_cal_start
);
    import conv_port_pkg::*;

    pin_sync_if pins ();
    port_state_t st;
    logic sclk_prev;
    logic [LEN_W-1:0] bit_cnt;
    logic [REG_W-1:0] in_sh;
    logic [REG_W-1:0] out_sh;
    logic [ADDR_W-1:0] addr;
    logic cont_mode;
    logic launched;
    // RULE18 twelve register slots
    logic [REG_W-1:0] regs [NUM_REGS];

    // ==========================================================
    // pin sampling
    pin_sync u_sync (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_sclk(i_sclk),
        .i_cs_n(i_cs_n),
        .i_din(i_din),
        .i_pol(i_edge_polarity_select),
        .sync(pins.src)
    );

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            // track the idle level so a parked-high clock is not an edge
            sclk_prev <= pins.sclk;
        end else begin
            sclk_prev <= pins.sclk;
        end
    end

    // ==========================================================
    // edge and command decode
    logic cs_act;
    logic rise;
    logic fall;
    logic sample_edge;
    logic shift_edge;
    logic [REG_W-1:0] next_in;
    logic [1:0] cmd_dir;
    logic [ADDR_W-1:0] cmd_addr;
    logic [LEN_W-1:0] cur_len;
    logic cmd_done;
    logic wr_done;
    logic rd_done;
    logic stop_seen;
    logic load_rd;
    logic reload;
    logic data_rd_done;
    logic cal_word;

    assign cs_act = ~pins.cs_n;
    assign rise = pins.sclk & ~sclk_prev;
    assign fall = ~pins.sclk & sclk_prev;
    // RULE3 RULE5 capture edge
    assign sample_edge = cs_act & (pins.edge_polarity_select ? rise : fall);
    // RULE9 RULE10 launch edge
    assign shift_edge = cs_act & (pins.edge_polarity_select ? fall : rise);
    assign next_in = {in_sh[REG_W-2:0], pins.din};
    assign cmd_dir = next_in[DIR_HI_BIT:DIR_LO_BIT];
    assign cmd_addr = next_in[ADDR_W-1:0];
    assign cur_len = reg_len(addr);
    assign cmd_done = st == ST_CMD && sample_edge && bit_cnt == LEN_8 - 5'h01;
    // RULE1 RULE2 full length reached
    assign wr_done = st == ST_WRITE && sample_edge
        && bit_cnt == cur_len - 5'h01;
    assign rd_done = st == ST_READ && sample_edge
        && bit_cnt == cur_len - 5'h01;
    // RULE24 exit byte watched on data-in during continuous reads
    assign stop_seen = cont_mode && st == ST_READ && sample_edge
        && bit_cnt[2:0] == 3'h7 && cmd_dir == DIR_STOP;
    assign load_rd = cmd_done && (cmd_dir == DIR_READ || cmd_dir == DIR_CONT);
    assign reload = rd_done && cont_mode && !stop_seen;
    assign data_rd_done = rd_done && !stop_seen && addr == ADDR_DATA;
    assign cal_word = next_in[MODE_SEL_HI:MODE_SEL_LO] == MODE_CAL_ZERO
        || next_in[MODE_SEL_HI:MODE_SEL_LO] == MODE_CAL_FULL;

    // ==========================================================
    // command / write / read sequencing
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            // RULE23 first transfer is a command
            st <= ST_CMD;
            bit_cnt <= '0;
            in_sh <= '0;
            addr <= ADDR_STATUS;
            cont_mode <= 1'b0;
        end else if (!cs_act) begin
            // RULE26 counter restarts between frames
            bit_cnt <= '0;
        end else if (sample_edge) begin
            in_sh <= next_in;
            case (st)
                ST_CMD: begin
                    if (cmd_done) begin
                        bit_cnt <= '0;
                        addr <= cmd_addr;
                        // RULE19 RULE24 direction field
                        case (cmd_dir)
                            DIR_WRITE: st <= ST_WRITE;
                            DIR_READ: st <= ST_READ;
                            DIR_CONT: begin
                                st <= ST_READ;
                                cont_mode <= 1'b1;
                            end
                            default: cont_mode <= 1'b0;
                        endcase
                    end else begin
                        bit_cnt <= bit_cnt + 5'h01;
                    end
                end
                ST_WRITE: begin
                    // RULE25 back to command after the write
                    if (wr_done) begin
                        st <= ST_CMD;
                        bit_cnt <= '0;
                    end else begin
                        bit_cnt <= bit_cnt + 5'h01;
                    end
                end
                default: begin
                    if (stop_seen) begin
                        st <= ST_CMD;
                        cont_mode <= 1'b0;
                        bit_cnt <= '0;
                    end else if (rd_done) begin
                        bit_cnt <= '0;
                        st <= cont_mode ? ST_READ : ST_CMD;
                    end else begin
                        bit_cnt <= bit_cnt + 5'h01;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // read value, msb aligned to the top of the shifter
    logic [ADDR_W-1:0] rd_addr;
    logic [REG_W-1:0] rd_word;
    logic [REG_W-1:0] rd_aligned;

    // RULE16 data word readable again
    always_comb begin
        rd_addr = load_rd ? cmd_addr : addr;
        rd_word = '0;
        if (rd_addr == ADDR_STATUS) begin
            rd_word[STATUS_RDY_BIT] = o_rdy_n;
        end else if (rd_addr <= ADDR_LAST) begin
            rd_word = regs[rd_addr];
        end
        case (reg_len(rd_addr))
            LEN_8: rd_aligned = {rd_word[7:0], 16'h0000};
            LEN_16: rd_aligned = {rd_word[15:0], 8'h00};
            default: rd_aligned = rd_word;
        endcase
    end

    // ==========================================================
    // output shifter
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            out_sh <= '0;
            launched <= 1'b0;
        end else if (load_rd || reload) begin
            // RULE8 parallel copy at read start
            out_sh <= rd_aligned;
            launched <= 1'b0;
        end else if (st == ST_READ && shift_edge) begin
            // RULE12 a launch edge before any capture edge keeps the msb already shown
            if (launched) begin
                out_sh <= {out_sh[REG_W-2:0], 1'b0};
            end
            launched <= 1'b1;
        end else if (st == ST_READ && sample_edge) begin
            launched <= 1'b1;
        end
    end

    // ==========================================================
    // data-out pin, driven only in reads with select low
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_dout <= 1'b0;
            o_dout_oe_n <= 1'b1;
        end else begin
            // RULE11 msb appears as soon as select falls
            o_dout <= out_sh[REG_W-1];
            // RULE26 RULE27 released outside read frames
            o_dout_oe_n <= !(cs_act && st == ST_READ);
        end
    end

    // ==========================================================
    // register file
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs[i] <= REG_RST;
            end
        end else begin
            // RULE1 commit only on the final bit
            if (wr_done && addr > ADDR_DATA && addr <= ADDR_LAST) begin
                case (cur_len)
                    LEN_8: regs[addr] <= {16'h0000, next_in[7:0]};
                    LEN_16: regs[addr] <= {8'h00, next_in[15:0]};
                    default: regs[addr] <= next_in;
                endcase
            end
            if (i_result_valid) begin
                regs[ADDR_DATA] <= i_result;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_mode_load <= 1'b0;
            o_cal_start <= 1'b0;
        end else begin
            o_mode_load <= wr_done && addr == ADDR_MODE;
            // RULE20 calibration words
            o_cal_start <= wr_done && addr == ADDR_MODE && cal_word;
        end
    end

    assign o_mode = regs[ADDR_MODE];
    assign o_filter = regs[ADDR_FILTER];
    assign o_dac = regs[ADDR_DAC];

    // ==========================================================
    // ready line; a fresh result beats a same-cycle clear
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_rdy_n <= 1'b1;
        end else if (i_result_valid || i_cal_done) begin
            // RULE13 RULE21 new word or calibration finished
            o_rdy_n <= 1'b0;
        end else if (data_rd_done || i_update_soon || o_cal_start) begin
            // RULE14 RULE15 read complete or update coming
            o_rdy_n <= 1'b1;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_srst);

    a_sample_edge_pol: assert property ( // RULE3
        sample_edge |-> pins.sclk == pins.edge_polarity_select)
        else $error("capture on wrong clock edge");
    a_write_len_commit: assert property ( // RULE2
        wr_done |-> bit_cnt + 5'h01 == reg_len(addr)
            ##1 st == ST_CMD)
        else $error("write committed at wrong bit count");
    a_write_store: assert property ( // RULE1
        wr_done && addr == ADDR_DAC
            |=> regs[ADDR_DAC][7:0] == $past(next_in[7:0]))
        else $error("dac register not loaded from shifter");
    a_read_copy: assert property ( // RULE8
        load_rd |=> out_sh == $past(rd_aligned) && !launched)
        else $error("output shifter not loaded at read start");
    a_shift_step: assert property ( // RULE9
        st == ST_READ && shift_edge && launched && !reload
            |=> out_sh[REG_W-1:1] == $past(out_sh[REG_W-2:0]))
        else $error("output shifter did not advance");
    a_dout_release: assert property ( // RULE26
        !cs_act |=> o_dout_oe_n)
        else $error("data-out driven while deselected");
    a_no_drive_write: assert property ( // RULE27
        st == ST_WRITE ##1 st == ST_WRITE |-> o_dout_oe_n)
        else $error("data-out driven during write");
    a_rdy_low_result: assert property ( // RULE13
        i_result_valid |=> !o_rdy_n ##1 (!o_rdy_n || $past(data_rd_done)
            || $past(i_update_soon) || $past(o_cal_start)))
        else $error("ready not low after result");
    a_rdy_high_read: assert property ( // RULE14
        data_rd_done && !i_result_valid && !i_cal_done |=> o_rdy_n)
        else $error("ready not high after data read");
    a_rdy_high_update: assert property ( // RULE15
        i_update_soon && !i_result_valid && !i_cal_done |=> o_rdy_n)
        else $error("ready not raised before update");
    a_cal_rdy: assert property ( // RULE21
        i_cal_done |=> !o_rdy_n)
        else $error("ready not low after calibration");
    a_cont_exit: assert property ( // RULE24
        stop_seen |=> !cont_mode && st == ST_CMD)
        else $error("continuous read not left");

    c_mode_write: cover property (o_mode_load && o_cal_start);
    c_data_read: cover property (data_rd_done);
    c_cont_stop: cover property (reload ##[1:1000] stop_seen);
endmodule
`default_nettype wire

// ---- testbench/host_model.sv ----
// host serial master model driving clock, select and data-in
// assumes the polarity strap only changes while no frame is open
`timescale 1ns/100ps
`default_nettype none
module host_model (
    input wire logic i_pol,
    input wire logic i_dout,
    input wire logic i_dout_oe_n,
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_din
);
    // ==========================================================
    // frame engine
    localparam realtime HALF = 62.5;
    logic oe_seen;

    initial begin
        o_sclk = 1'b1;
        o_cs_n = 1'b1;
        o_din = 1'b0;
        oe_seen = 1'b0;
    end

    task automatic park();
        #1;
        o_sclk = i_pol;
        #HALF;
    endtask

    // separate data wires, din low when reading
    task automatic xfer(input logic [31:0] tx, input int n, input bit fs,
                        input bit keep, output logic [31:0] rx);
        rx = 32'h0;
        oe_seen = 1'b0;
        if (fs) begin
            o_sclk = ~i_pol;
            #HALF;
        end
        o_cs_n = 1'b0;
        if (fs) begin
            o_din = tx[n-1];
        end
        #HALF;
        for (int i = n - 1; i >= 0; i--) begin
            if (!fs || i != n - 1) begin
                o_sclk = ~i_pol;
                o_din = tx[i];
                #HALF;
            end
            // a released line reads as the inverse of its last bit
            rx = {rx[30:0], i_dout ^ i_dout_oe_n};
            if (i_dout_oe_n === 1'b0) begin
                oe_seen = 1'b1;
            end
            o_sclk = i_pol;
            #HALF;
        end
        // released line must not keep showing the last bit
        o_din = ~o_din;
        // deselect long enough for the sampler to see it
        if (!keep) begin
            o_cs_n = 1'b1;
            #HALF;
        end
    endtask
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
// self-checking bench for the converter serial port
// assumes host_model as far side and the converter inputs from the bench
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin \
    n_fail++; $display("unexpected at %0t got %h exp %h", $time, got, exp); \
    end end
module tb;
    import conv_port_pkg::*;
    // ==========================================================
    // signals
    logic i_clk = 1'b0;
    logic i_srst = 1'b1;
    logic edge_polarity_select = 1'b1;
    logic i_result_valid = 1'b0;
    logic i_update_soon = 1'b0;
    logic i_cal_done = 1'b0;
    logic [REG_W-1:0] i_result = 24'h000000;
    wire sclk, cs_n, din, o_dout, o_dout_oe_n, o_rdy_n;
    wire o_mode_load, o_cal_start;
    wire [REG_W-1:0] o_mode, o_filter, o_dac;
    logic [31:0] rx;
    int n_fail = 0;
    int n_checks = 0;
    int n_cal = 0;
    int n_load = 0;
    int cycles = 0;

    always #2.5 i_clk = ~i_clk;

    converter_serial_port uut (.i_clk(i_clk), .i_srst(i_srst),
        .i_sclk(sclk), .i_cs_n(cs_n), .i_din(din),
        .i_edge_polarity_select(edge_polarity_select), .i_result_valid(i_result_valid),
        .i_result(i_result), .i_update_soon(i_update_soon),
        .i_cal_done(i_cal_done), .o_dout(o_dout),
        .o_dout_oe_n(o_dout_oe_n), .o_rdy_n(o_rdy_n), .o_mode(o_mode),
        .o_filter(o_filter), .o_dac(o_dac), .o_mode_load(o_mode_load),
        .o_cal_start(o_cal_start));

    host_model host (.i_pol(edge_polarity_select), .i_dout(o_dout),
        .i_dout_oe_n(o_dout_oe_n), .o_sclk(sclk), .o_cs_n(cs_n),
        .o_din(din));

    // ==========================================================
    // helpers
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // pulses are one cycle wide, so settle two cycles before judging
    always @(posedge i_clk) begin
        cycles++;
        if (o_cal_start === 1'b1) n_cal++;
        if (o_mode_load === 1'b1) n_load++;
        if (cycles == 40000) begin
            n_fail++;
            complete_run();
        end
    end

    task automatic pulse(input logic [2:0] p, input logic [23:0] r);
        @(posedge i_clk);
        {i_result_valid, i_update_soon, i_cal_done} <= p;
        i_result <= r;
        @(posedge i_clk);
        {i_result_valid, i_update_soon, i_cal_done} <= 3'h0;
        repeat (2) @(posedge i_clk);
    endtask

    task automatic set_pol(input logic v);
        @(posedge i_clk);
        edge_polarity_select <= v;
        @(posedge i_clk);
        host.park();
    endtask

    task automatic wr(input logic [7:0] cmd, input logic [31:0] d,
                      input int n);
        host.xfer({24'h0, cmd}, 8, 1'b0, 1'b0, rx);
        `CHK(host.oe_seen, 1'b0)
        host.xfer(d, n, 1'b0, 1'b0, rx);
        `CHK(host.oe_seen, 1'b0)
        repeat (8) @(posedge i_clk);
    endtask

    task automatic rd(input logic [7:0] cmd, input int n, input bit fs);
        host.xfer({24'h0, cmd}, 8, 1'b0, 1'b0, rx);
        host.xfer(32'h0, n, fs, 1'b0, rx);
        repeat (8) @(posedge i_clk);
    endtask

    // ==========================================================
    // scenarios
    task automatic t_reset();
        `CHK(o_dout_oe_n, 1'b1)
        `CHK(o_rdy_n, 1'b1)
    endtask

    task automatic t_write();
        wr(8'h03, 32'h001332, 24);
        `CHK(o_filter, 24'h001332)
        host.xfer(32'h04, 8, 1'b0, 1'b0, rx);
        host.xfer(32'hF, 4, 1'b0, 1'b0, rx);
        repeat (8) @(posedge i_clk);
        `CHK(o_dac, 24'h000000)
        host.xfer(32'hA5, 8, 1'b0, 1'b0, rx);
        repeat (8) @(posedge i_clk);
        `CHK(o_dac, 24'h0000A5)
        wr(8'h03, 32'h12ABCDFF, 32);
        `CHK(o_filter, 24'h12ABCD)
        wr(8'h04, 32'h5A, 8);
        `CHK(o_dac, 24'h00005A)
    endtask

    task automatic t_cal();
        logic [15:0] w [2];
        int c0;
        int l0;
        w = '{16'hB174, 16'h9174};
        for (int i = 0; i < 2; i++) begin
            c0 = n_cal;
            l0 = n_load;
            wr(8'h02, {16'h0, w[i]}, 16);
            `CHK(o_mode, {8'h00, w[i]})
            `CHK(n_load - l0, 1)
            `CHK(n_cal - c0, 1)
            `CHK(o_rdy_n, 1'b1)
            pulse(3'b001, 24'h0);
            `CHK(o_rdy_n, 1'b0)
        end
    endtask

    task automatic t_read();
        pulse(3'b010, 24'h0);
        `CHK(o_rdy_n, 1'b1)
        pulse(3'b100, 24'hC3A55A);
        `CHK(o_rdy_n, 1'b0)
        rd(8'h11, 24, 1'b0);
        `CHK(rx[23:0], 24'hC3A55A)
        `CHK(o_rdy_n, 1'b1)
        `CHK(o_dout_oe_n, 1'b1)
        rd(8'h10, 8, 1'b0);
        `CHK(rx[STATUS_RDY_BIT], 1'b1)
        rd(8'h1F, 8, 1'b0);
        `CHK(rx[7:0], 8'h00)
        set_pol(1'b0);
        rd(8'h11, 24, 1'b1);
        `CHK(rx[23:0], 24'hC3A55A)
    endtask

    task automatic t_three_wire();
        host.xfer(32'h04, 8, 1'b0, 1'b1, rx);
        host.xfer(32'h3C, 8, 1'b0, 1'b0, rx);
        repeat (8) @(posedge i_clk);
        `CHK(o_dac, 24'h00003C)
    endtask

    task automatic t_cont();
        host.xfer(32'h21, 8, 1'b0, 1'b0, rx);
        for (int i = 0; i < 2; i++) begin
            host.xfer(32'h0, 24, 1'b0, 1'b0, rx);
            `CHK(rx[23:0], 24'hC3A55A)
        end
        host.xfer(32'h30, 8, 1'b0, 1'b0, rx);
        rd(8'h1F, 8, 1'b0);
        `CHK(rx[7:0], 8'h00)
    endtask

    initial begin
        repeat (4) @(posedge i_clk);
        i_srst <= 1'b0;
        repeat (4) @(posedge i_clk);
        t_reset();
        t_write();
        t_cal();
        t_read();
        t_three_wire();
        t_cont();
        complete_run();
    end
endmodule
`default_nettype wire
